// ==== logic/mmd_consts.svh ====
// Purpose: Constants for the memory map decoder: region bounds, register offsets, fields.
// Assumes: 16-bit processor addresses, 8-bit registers, AHB-Lite word-per-register bus.
// Notes:   Region bounds are inclusive byte addresses of the processor space.
// Operation
// - Decode 16-bit address, one region per access
// - 0x0000-0x0045 I/O registers, 0x0046-0x005F reserved
// - 0x0060-0x025F is 512 bytes RAM
// - 0xBC00-0xFBFF is 16384 bytes user flash
// - 0xFFDC-0xFFFF vectors, 0xFFD1-0xFFDB reserved
// - Monitor ROM at 0xFC00-0xFDFF and 0xFE10-0xFFCE
// - 0xFE00 break status; 0xFE02/07/09-0B reserved
// - 0xFE01 reset cause, 0xFE03 break flag control
// - 0xFE04-0xFE06 interrupt source status one-three
// - 0xFE08 flash program control register
// - 0xFE0C/0D breakpoint high/low; 0xFE0F reserved
// - 0xFE0E breakpoint status and control
// - 0xFFCF flash block protect, stored in flash
// - 0xFFD0 option byte, stored in flash
// - 0xFFFF also selects watchdog control
// - Config two writable once per reset
// - Trip-level bits cleared only by power-on; here the first CFG2 write after any reset also reloads them
// - Ext irq: pending RO, ack WO, mask, mode
// - Eight keypad enable bits, reset zero
`ifndef MMD_CONSTS_SVH
`define MMD_CONSTS_SVH

// ==========================================================
// Region bounds
`define MMD_IO_LO        16'h0000
`define MMD_IO_HI        16'h0045
`define MMD_RSV_IO_HI    16'h005F
`define MMD_RAM_LO       16'h0060
`define MMD_RAM_HI       16'h025F
`define MMD_FLASH_LO     16'hBC00
`define MMD_FLASH_HI     16'hFBFF
`define MMD_ROM1_LO      16'hFC00
`define MMD_ROM1_HI      16'hFDFF
`define MMD_ROM2_LO      16'hFE10
`define MMD_ROM2_HI      16'hFFCE
`define MMD_VEC_LO       16'hFFDC
`define MMD_VEC_HI       16'hFFFF

// ==========================================================
// Register addresses (processor space)
`define MMD_A_KBIE       16'h001B
`define MMD_A_EXTIRQ     16'h001D
`define MMD_A_CFG2       16'h001E
`define MMD_A_CFG1       16'h001F
`define MMD_A_BRKSTAT    16'hFE00
`define MMD_A_RSTCAUSE   16'hFE01
`define MMD_A_BRKFLAG    16'hFE03
`define MMD_A_IRQS1      16'hFE04
`define MMD_A_IRQS2      16'hFE05
`define MMD_A_IRQS3      16'hFE06
`define MMD_A_FLCTL      16'hFE08
`define MMD_A_BREAKPOINT_ADDR_HIGH       16'hFE0C
`define MMD_A_BREAKPOINT_ADDR_LOW       16'hFE0D
`define MMD_A_BRKSC      16'hFE0E
`define MMD_A_FLPROT     16'hFFCF
`define MMD_A_OPTION     16'hFFD0
`define MMD_A_WDOG       16'hFFFF

// ==========================================================
// AHB side: a processor address at byte index n sits at 4*n
`define MMD_BUS_SHIFT    2

// ==========================================================
// Field layouts and masks
`define MMD_EXT_PEND     3
`define MMD_EXT_ACK      2
`define MMD_EXT_MASK     1
`define MMD_EXT_MODE     0
`define MMD_EXT_WMASK    8'h03
`define MMD_CFG2_TRIP    8'h18
`define MMD_CFG2_WMASK   8'h9F
`define MMD_CFG1_WMASK   8'h97
`define MMD_BSW_BIT      1
`define MMD_BFLAG_BIT    7
`define MMD_FLCTL_WMASK  8'h0F
`define MMD_ZERO8        8'h00

`endif

// ==== logic/mmd_pkg.sv ====
// Purpose: Types for the memory map decoder.
// Assumes: Constants come from mmd_consts.svh.
// Notes:   Region enum is the decoder's one-hot-in-meaning answer.
package mmd_pkg;

  // ==========================================================
  // Region selected by a processor address
  typedef enum logic [3:0] {
    MMD_RG_NONE,
    MMD_RG_IO,
    MMD_RG_RAM,
    MMD_RG_FLASH,
    MMD_RG_ROM,
    MMD_RG_SYSREG,
    MMD_RG_FLASHREG,
    MMD_RG_VECTOR
  } mmd_region_e;

  // Bus phase of the slave
  typedef enum logic [0:0] {
    MMD_PH_IDLE,
    MMD_PH_DATA
  } mmd_phase_e;

  // Status inputs sampled from the rest of the chip
  typedef struct packed {
    logic [7:0] reset_cause;
    logic [7:0] irq_src_one;
    logic [7:0] irq_src_two;
    logic [7:0] irq_src_three;
    logic [7:0] flash_protect;
    logic [7:0] option_val;
    logic       ext_irq_edge;
  } mmd_status_s;

  // Register state of the decoder; trip bits and pin synchroniser are kept outside
  typedef struct packed {
    mmd_phase_e  phase;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  kbie;
    logic        ext_pend;
    logic        ext_mask;
    logic        ext_mode;
    logic        ext_ack;
    logic [7:0]  cfg2;
    logic        cfg2_done;
    logic [7:0]  cfg1;
    logic        brk_sbsw;
    logic        brk_flag;
    logic [7:0]  flctl;
    logic [7:0]  breakpoint_addr_high;
    logic [7:0]  breakpoint_addr_low;
    logic [7:0]  brksc;
    logic        wdog_kick;
    logic [31:0] rdata;
  } mmd_state_s;

endpackage

// ==== logic/mmd_decoder.sv ====
// Purpose: Memory map decoder and low/high page system registers, AHB-Lite slave.
// Assumes: Word-per-byte mapping; status inputs come from clk_sys logic, ext irq pin is async.
// Notes:   Storage regions are only selected here; storage lives outside.
`timescale 1ns/1ns
`include "mmd_consts.svh"

module mmd_decoder
  import mmd_pkg::*;
(
  input  wire logic        clk_sys,       // System clock, 100 MHz
  input  wire logic        nrst,          // Async reset, any cause
  input  wire logic        npor,          // Async power-on reset only
  input  wire logic        hsel,          // AHB slave select
  input  wire logic [31:0] haddr,         // AHB byte address
  input  wire logic [1:0]  htrans,        // AHB transfer type
  input  wire logic        hwrite,        // AHB write
  input  wire logic [2:0]  hsize,         // AHB size, word only
  input  wire logic [31:0] hwdata,        // AHB write data
  input  wire logic        hready,        // AHB bus ready
  output logic      [31:0] hrdata,        // AHB read data
  output logic             hreadyout,     // AHB slave ready
  output logic             hresp,         // AHB response, always OKAY
  input  wire logic        ext_irq_pin,   // External interrupt pin, edge or level by mode, async
  input  wire mmd_status_s status_in,     // Status from chip, same clock
  output mmd_region_e      region,        // Region of last access
  output logic      [7:0]  keypad_enable_bits, // Keypad enables
  output logic             ext_irq_req,   // Pending and unmasked
  output logic             ext_irq_mode,  // Edge/level mode bit
  output logic      [7:0]  cfg_two,       // Config two contents
  output logic      [7:0]  cfg_one,       // Config one contents
  output logic      [7:0]  flash_ctl,     // Flash control contents
  output logic      [15:0] brk_addr,      // Breakpoint address
  output logic      [7:0]  brk_ctl,       // Breakpoint status/control
  output logic             wdog_kick      // Pulse on watchdog write
);

  // ==========================================================
  // Address decode function, used for the region output only
  function automatic mmd_region_e decode(input logic [15:0] a);
    mmd_region_e rg;
    rg = MMD_RG_NONE;
    if (a <= `MMD_IO_HI) begin
      rg = MMD_RG_IO;
    end else if (a >= `MMD_RAM_LO && a <= `MMD_RAM_HI) begin
      rg = MMD_RG_RAM;
    end else if (a >= `MMD_FLASH_LO && a <= `MMD_FLASH_HI) begin
      rg = MMD_RG_FLASH;
    end else if ((a >= `MMD_ROM1_LO && a <= `MMD_ROM1_HI) ||
                 (a >= `MMD_ROM2_LO && a <= `MMD_ROM2_HI)) begin
      rg = MMD_RG_ROM;
    end else if (a == `MMD_A_BRKSTAT || a == `MMD_A_RSTCAUSE || a == `MMD_A_BRKFLAG ||
                 a == `MMD_A_IRQS1 || a == `MMD_A_IRQS2 || a == `MMD_A_IRQS3 ||
                 a == `MMD_A_FLCTL || a == `MMD_A_BREAKPOINT_ADDR_HIGH || a == `MMD_A_BREAKPOINT_ADDR_LOW ||
                 a == `MMD_A_BRKSC) begin
      rg = MMD_RG_SYSREG;
    end else if (a == `MMD_A_FLPROT || a == `MMD_A_OPTION) begin
      rg = MMD_RG_FLASHREG;
    end else if (a >= `MMD_VEC_LO) begin
      rg = MMD_RG_VECTOR;
    end
    return rg;
  endfunction

  // ==========================================================
  // State, synchroniser and trip bits
  mmd_state_s  st_r;              // All bus-reset state
  mmd_state_s  st_nxt;            // Next value
  logic [1:0]  trip_r;            // Trip bits, power-on only
  logic [1:0]  trip_nxt;
  logic        irq_meta_r;        // First sync stage
  logic        irq_sync_r;        // Second sync stage
  logic        irq_prev_r;        // Edge detect history
  logic [15:0] bus_a;             // Processor address of request
  logic        take;              // Address phase accepted
  logic        wr_ok;             // Data phase of a write
  logic [7:0]  wd;                // Write byte
  logic        ext_evt;           // Edge or level event

  assign bus_a = haddr[`MMD_BUS_SHIFT +: 16];
  assign take  = hsel && hready && htrans[1];
  assign wd    = hwdata[7:0];
  assign wr_ok = (st_r.phase == MMD_PH_DATA) && st_r.wr;
  // Level mode keeps pending while pin stays asserted
  assign ext_evt = st_r.ext_mode ? irq_sync_r : (irq_sync_r && !irq_prev_r);

  // ==========================================================
  // Pin synchroniser, only the second stage is read
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq_meta_r <= 1'b0;
      irq_sync_r <= 1'b0;
      irq_prev_r <= 1'b0;
    end else begin
      irq_meta_r <= ext_irq_pin;
      irq_sync_r <= irq_meta_r;
      irq_prev_r <= irq_sync_r;
    end
  end

  // ==========================================================
  // Next-state logic
  always_comb begin
    st_nxt           = st_r;
    trip_nxt         = trip_r;
    st_nxt.wdog_kick = 1'b0;
    st_nxt.ext_ack   = 1'b0;
    // Address phase capture; writes commit in the data phase
    if (take) begin
      st_nxt.phase = MMD_PH_DATA;
      st_nxt.wr    = hwrite;
      st_nxt.addr  = bus_a;
    end else if (hready) begin
      st_nxt.phase = MMD_PH_IDLE;
    end
    // Read data is built at address phase, reserved bits zero
    if (take && !hwrite) begin
      st_nxt.rdata = {24'h0000_00, `MMD_ZERO8};
      case (bus_a)
        `MMD_A_KBIE:      st_nxt.rdata[7:0] = st_r.kbie;
        `MMD_A_EXTIRQ:    st_nxt.rdata[7:0] = {4'h0, st_r.ext_pend, 1'b0,
                                               st_r.ext_mask, st_r.ext_mode};
        `MMD_A_CFG2:      st_nxt.rdata[7:0] = st_r.cfg2 | {3'b000, trip_r, 3'b000};
        `MMD_A_CFG1:      st_nxt.rdata[7:0] = st_r.cfg1;
        `MMD_A_BRKSTAT:   st_nxt.rdata[7:0] = {6'h00, st_r.brk_sbsw, 1'b0};
        `MMD_A_RSTCAUSE:  st_nxt.rdata[7:0] = status_in.reset_cause;
        `MMD_A_BRKFLAG:   st_nxt.rdata[7:0] = {st_r.brk_flag, 7'h00};
        `MMD_A_IRQS1:     st_nxt.rdata[7:0] = status_in.irq_src_one;
        `MMD_A_IRQS2:     st_nxt.rdata[7:0] = status_in.irq_src_two;
        `MMD_A_IRQS3:     st_nxt.rdata[7:0] = status_in.irq_src_three;
        `MMD_A_FLCTL:     st_nxt.rdata[7:0] = st_r.flctl;
        `MMD_A_BREAKPOINT_ADDR_HIGH:      st_nxt.rdata[7:0] = st_r.breakpoint_addr_high;
        `MMD_A_BREAKPOINT_ADDR_LOW:      st_nxt.rdata[7:0] = st_r.breakpoint_addr_low;
        `MMD_A_BRKSC:     st_nxt.rdata[7:0] = st_r.brksc;
        `MMD_A_FLPROT:    st_nxt.rdata[7:0] = status_in.flash_protect;
        `MMD_A_OPTION:    st_nxt.rdata[7:0] = status_in.option_val;
        default:          st_nxt.rdata[7:0] = `MMD_ZERO8;
      endcase
    end
    // Hardware event; set beats the acknowledge in the same cycle
    if (wr_ok && st_r.addr == `MMD_A_EXTIRQ && wd[`MMD_EXT_ACK]) begin
      st_nxt.ext_pend = 1'b0;
      st_nxt.ext_ack  = 1'b1;
    end
    if (ext_evt) begin
      st_nxt.ext_pend = 1'b1;
    end
    // Data phase writes
    if (wr_ok) begin
      case (st_r.addr)
        `MMD_A_KBIE:     st_nxt.kbie = wd;
        `MMD_A_EXTIRQ: begin
          st_nxt.ext_mask = wd[`MMD_EXT_MASK];
          st_nxt.ext_mode = wd[`MMD_EXT_MODE];
        end
        `MMD_A_CFG2: begin
          if (!st_r.cfg2_done) begin
            st_nxt.cfg2      = wd & `MMD_CFG2_WMASK & ~`MMD_CFG2_TRIP;
            trip_nxt         = wd[4:3];
            st_nxt.cfg2_done = 1'b1;
          end
        end
        `MMD_A_CFG1:     st_nxt.cfg1 = wd & `MMD_CFG1_WMASK;
        `MMD_A_BRKSTAT: begin
          if (!wd[`MMD_BSW_BIT]) begin
            st_nxt.brk_sbsw = 1'b0;
          end
        end
        `MMD_A_BRKFLAG:  st_nxt.brk_flag = wd[`MMD_BFLAG_BIT];
        `MMD_A_FLCTL:    st_nxt.flctl = wd & `MMD_FLCTL_WMASK;
        `MMD_A_BREAKPOINT_ADDR_HIGH:     st_nxt.breakpoint_addr_high = wd;
        `MMD_A_BREAKPOINT_ADDR_LOW:     st_nxt.breakpoint_addr_low = wd;
        `MMD_A_BRKSC:    st_nxt.brksc = wd;
        `MMD_A_WDOG:     st_nxt.wdog_kick = 1'b1;
        default: begin
          // Storage regions and reserved space hold nothing here
        end
      endcase
    end
  end

  // ==========================================================
  // State registers; trip bits only see the power-on reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge npor) begin
    if (!npor) begin
      trip_r <= 2'b00;
    end else begin
      trip_r <= trip_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign hrdata             = st_r.rdata;
  assign hreadyout          = 1'b1;                // Zero wait states
  assign hresp              = 1'b0;
  assign region             = decode(st_r.addr);
  assign keypad_enable_bits = st_r.kbie;
  assign ext_irq_req        = st_r.ext_pend && !st_r.ext_mask;
  assign ext_irq_mode       = st_r.ext_mode;
  assign cfg_two            = st_r.cfg2 | {3'b000, trip_r, 3'b000};
  assign cfg_one            = st_r.cfg1;
  assign flash_ctl          = st_r.flctl;
  assign brk_addr           = {st_r.breakpoint_addr_high, st_r.breakpoint_addr_low};
  assign brk_ctl            = st_r.brksc;
  assign wdog_kick          = st_r.wdog_kick;

  // ==========================================================
  // Checks
  a_cfg_once_lock: assert property (@(posedge clk_sys) disable iff (!nrst)
    (st_r.cfg2_done && wr_ok && st_r.addr == `MMD_A_CFG2) |=> $stable(st_r.cfg2))
    else $error("config two changed after its one write");
  a_kbie_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    (wr_ok && st_r.addr == `MMD_A_KBIE) |=> keypad_enable_bits == $past(hwdata[7:0]))
    else $error("keypad enable write lost");
  a_pend_set: assert property (@(posedge clk_sys) disable iff (!nrst)
    ext_evt |=> st_r.ext_pend)
    else $error("pending flag not set by event");
  a_ack_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
    (st_r.ext_ack && !$past(ext_evt)) |-> !st_r.ext_pend)
    else $error("acknowledge did not clear pending");
  a_ext_readzero: assert property (@(posedge clk_sys) disable iff (!nrst)
    (take && !hwrite && bus_a == `MMD_A_EXTIRQ) |=> (hrdata[7:4] == 4'h0 && hrdata[2] == 1'b0))
    else $error("unimplemented ext irq bits read nonzero");
  a_ram_region: assert property (@(posedge clk_sys) disable iff (!nrst)
    (take && bus_a >= `MMD_RAM_LO && bus_a <= `MMD_RAM_HI) |=> region == MMD_RG_RAM)
    else $error("ram address not decoded to ram");
  a_gap_none: assert property (@(posedge clk_sys) disable iff (!nrst)
    (take && bus_a > `MMD_RAM_HI && bus_a < `MMD_FLASH_LO) |=> region == MMD_RG_NONE)
    else $error("unimplemented space decoded to storage");
  a_wdog_pulse: assert property (@(posedge clk_sys) disable iff (!nrst)
    (wr_ok && st_r.addr == `MMD_A_WDOG) |=> (wdog_kick ##1 !wdog_kick))
    else $error("watchdog write pulse wrong");
  a_brk_addr: assert property (@(posedge clk_sys) disable iff (!nrst)
    (wr_ok && st_r.addr == `MMD_A_BREAKPOINT_ADDR_LOW) |=> brk_addr[7:0] == $past(hwdata[7:0]))
    else $error("breakpoint low byte not stored");

  // Region decode for I/O, reserved I/O, flash, monitor ROM and vectors
  a_io_region: assert property (@(posedge clk_sys) disable iff (!nrst)
    (take && bus_a <= `MMD_IO_HI) |=> region == MMD_RG_IO)
    else $error("register address not decoded to i/o");

  a_rsv_io_none: assert property (@(posedge clk_sys) disable iff (!nrst)
    (take && bus_a > `MMD_IO_HI && bus_a <= `MMD_RSV_IO_HI) |=> region == MMD_RG_NONE)
    else $error("reserved i/o space decoded to storage");

  a_flash_region: assert property (@(posedge clk_sys) disable iff (!nrst)
    (take && bus_a >= `MMD_FLASH_LO && bus_a <= `MMD_FLASH_HI) |=> region == MMD_RG_FLASH)
    else $error("flash address not decoded to flash");

  a_rom_region: assert property (@(posedge clk_sys) disable iff (!nrst)
    (take && ((bus_a >= `MMD_ROM1_LO && bus_a <= `MMD_ROM1_HI) ||
              (bus_a >= `MMD_ROM2_LO && bus_a <= `MMD_ROM2_HI))) |=> region == MMD_RG_ROM)
    else $error("monitor address not decoded to rom");

  a_vec_region: assert property (@(posedge clk_sys) disable iff (!nrst)
    (take && bus_a >= `MMD_VEC_LO) |=> region == MMD_RG_VECTOR)
    else $error("vector address not decoded to vectors");

  // Only the low byte ever carries register data
  a_rdata_upper: assert property (@(posedge clk_sys) disable iff (!nrst)
    (take && !hwrite) |=> hrdata[31:8] == 24'h0000_00)
    else $error("read data upper bytes nonzero");

  // Trip bits load on the one allowed write and hold otherwise
  a_trip_load: assert property (@(posedge clk_sys) disable iff (!nrst)
    (wr_ok && st_r.addr == `MMD_A_CFG2 && !st_r.cfg2_done) |=>
      (cfg_two & `MMD_CFG2_TRIP) == ($past(hwdata[7:0]) & `MMD_CFG2_TRIP))
    else $error("trip bits not loaded by first write");

  a_trip_keep: assert property (@(posedge clk_sys) disable iff (!npor)
    !(wr_ok && st_r.addr == `MMD_A_CFG2 && !st_r.cfg2_done) |=> $stable(trip_r))
    else $error("trip bits changed without a write");

  // No kick without a write to the watchdog address
  a_kick_source: assert property (@(posedge clk_sys) disable iff (!nrst)
    wdog_kick |-> ($past(wr_ok) && $past(st_r.addr) == `MMD_A_WDOG))
    else $error("watchdog kick without a write");

  a_kbie_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    !(wr_ok && st_r.addr == `MMD_A_KBIE) |=> $stable(keypad_enable_bits))
    else $error("keypad enables changed without a write");

endmodule

// ==== tb/mmd_host.sv ====
// Purpose: AHB-Lite master standing in for the processor core bus.
// Assumes: One slave whose hreadyout is the bus hready; single word transfers.
// Notes:   Released address and data lines show the inverse of the last value.
`timescale 1ns/1ns

module mmd_host
  import mmd_pkg::*;
(
  input  wire logic        clk_sys,  // System clock
  input  wire logic        hready,   // Bus ready from the slave
  input  wire logic [31:0] hrdata,   // Read data
  output logic             hsel,     // Slave select
  output logic      [31:0] haddr,    // Byte address
  output logic      [1:0]  htrans,   // Transfer type
  output logic             hwrite,   // Write strobe
  output logic      [2:0]  hsize,    // Always a word
  output logic      [31:0] hwdata    // Write data
);
  // ==========================================================
  // Idle bus at time zero
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'b010;
    hwdata = 32'h0000_0000;
  end

  // ==========================================================
  // One single transfer; waits on hready, never on a fixed count
  task automatic xfer(input logic wr, input logic [15:0] pa, input logic [7:0] wd, output logic [31:0] rd);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    haddr  <= {14'h0000, pa, 2'b00}; // Byte address is four times the index
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    // Address taken: release it so stale values cannot pass for valid
    hsel   <= 1'b0;
    htrans <= 2'b00;
    haddr  <= ~haddr;
    hwdata <= {24'h00_0000, wd};
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
    hwdata <= ~hwdata;
  endtask
endmodule

// ==== tb/mmd_tb.sv ====
// Purpose: Self-checking bench for the memory map decoder.
// Assumes: Zero-wait slave; status inputs held steady.
// Notes:   Storage regions are judged by the region output only.
`timescale 1ns/1ns
`include "mmd_consts.svh"

module testbench
  import mmd_pkg::*;
;
  logic clk_sys, nrst, npor, hsel, hwrite, hreadyout, hresp, ext_irq_pin;
  logic ext_irq_req, ext_irq_mode, wdog_kick;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  keypad_enable_bits, cfg_two, cfg_one, flash_ctl, brk_ctl;
  logic [15:0] brk_addr;
  mmd_status_s status_in;                 // Status bytes from the chip
  mmd_region_e region;                    // Decoded region
  int          n_fail, n_tests, cycles;   // Counters
  // Region table: boundary addresses and the region each must select
  localparam logic [15:0] RG_A [22] = '{16'h0000, 16'h0045, 16'h0046, 16'h005F, 16'h0060, 16'h025F,
    16'h0260, 16'hBBFF, 16'hBC00, 16'hFBFF, 16'hFC00, 16'hFDFF, 16'hFE00, 16'hFE02, 16'hFE10,
    16'hFFCE, 16'hFFCF, 16'hFFD0, 16'hFFD1, 16'hFFDB, 16'hFFDC, 16'hFFFF};
  localparam mmd_region_e RG_E [22] = '{MMD_RG_IO, MMD_RG_IO, MMD_RG_NONE, MMD_RG_NONE, MMD_RG_RAM,
    MMD_RG_RAM, MMD_RG_NONE, MMD_RG_NONE, MMD_RG_FLASH, MMD_RG_FLASH, MMD_RG_ROM, MMD_RG_ROM,
    MMD_RG_SYSREG, MMD_RG_NONE, MMD_RG_ROM, MMD_RG_ROM, MMD_RG_FLASHREG, MMD_RG_FLASHREG,
    MMD_RG_NONE, MMD_RG_NONE, MMD_RG_VECTOR, MMD_RG_VECTOR};

  // ==========================================================
  // Instances
  mmd_decoder mmd_decoder_inst (.clk_sys(clk_sys), .nrst(nrst), .npor(npor), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ext_irq_pin(ext_irq_pin), .status_in(status_in), .region(region),
    .keypad_enable_bits(keypad_enable_bits), .ext_irq_req(ext_irq_req), .ext_irq_mode(ext_irq_mode),
    .cfg_two(cfg_two), .cfg_one(cfg_one), .flash_ctl(flash_ctl), .brk_addr(brk_addr), .brk_ctl(brk_ctl),
    .wdog_kick(wdog_kick));
  mmd_host mmd_host_inst (.clk_sys(clk_sys), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  // ==========================================================
  // Clock and hang guard; the tests need well under a thousand cycles
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      print_verdict();
    end
  end

  // ==========================================================
  // Shared helpers
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] pa, input logic [7:0] d);
    logic [31:0] t;
    mmd_host_inst.xfer(1'b1, pa, d, t);
  endtask
  task automatic rd_chk(input string nm, input logic [15:0] pa, input logic [31:0] exp);
    logic [31:0] t;
    mmd_host_inst.xfer(1'b0, pa, 8'h00, t);
    chk(nm, exp, t);
  endtask
  // Warm reset, or power-on reset when por is set
  task automatic do_reset(input logic por);
    @(posedge clk_sys);
    nrst <= 1'b0;
    npor <= ~por;
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    npor <= 1'b1;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_keypad();
    rd_chk("keypad reset", `MMD_A_KBIE, 32'h0000_0000);
    rd_chk("ext irq reset", `MMD_A_EXTIRQ, 32'h0000_0000);
    wr(`MMD_A_KBIE, 8'hA5);
    rd_chk("keypad rw", `MMD_A_KBIE, 32'h0000_00A5);
    chk("keypad out", 32'h0000_00A5, keypad_enable_bits);
    wr(16'h1000, 8'hFF);
    rd_chk("keypad kept", `MMD_A_KBIE, 32'h0000_00A5);
    chk("hresp", 32'h0000_0000, hresp);
  endtask
  task automatic t_cfg_once();
    wr(`MMD_A_CFG2, 8'hFF);
    rd_chk("cfg2 first", `MMD_A_CFG2, 32'h0000_009F);
    chk("cfg2 out", 32'h0000_009F, cfg_two);
    wr(`MMD_A_CFG2, 8'h00);
    rd_chk("cfg2 second", `MMD_A_CFG2, 32'h0000_009F);
    do_reset(1'b0);
    rd_chk("cfg2 warm", `MMD_A_CFG2, 32'h0000_0018);
    chk("cfg2 warm out", 32'h0000_0018, cfg_two);
    rd_chk("keypad warm", `MMD_A_KBIE, 32'h0000_0000);
    wr(`MMD_A_CFG2, 8'h01);
    rd_chk("cfg2 rewrite", `MMD_A_CFG2, 32'h0000_0001);
    do_reset(1'b1);
    rd_chk("cfg2 por", `MMD_A_CFG2, 32'h0000_0000);
    wr(`MMD_A_CFG1, 8'hFF);
    rd_chk("cfg1 bits", `MMD_A_CFG1, 32'h0000_0097);
    chk("cfg1 out", 32'h0000_0097, cfg_one);
  endtask
  task automatic t_ext_irq();
    wr(`MMD_A_EXTIRQ, 8'hFF);
    rd_chk("ext irq rw", `MMD_A_EXTIRQ, 32'h0000_0003);
    chk("ext irq mode", 32'h0000_0001, ext_irq_mode);
    wr(`MMD_A_EXTIRQ, 8'h00);
    @(posedge clk_sys);
    ext_irq_pin <= 1'b1;
    repeat (5) @(posedge clk_sys);
    ext_irq_pin <= 1'b0;
    rd_chk("ext irq pend", `MMD_A_EXTIRQ, 32'h0000_0008);
    chk("ext irq req", 32'h0000_0001, ext_irq_req);
    wr(`MMD_A_EXTIRQ, 8'h04);
    rd_chk("ext irq ack", `MMD_A_EXTIRQ, 32'h0000_0000);
    chk("ext irq req off", 32'h0000_0000, ext_irq_req);
    // Level mode: a held pin beats the acknowledge, the mask hides the request
    wr(`MMD_A_EXTIRQ, 8'h01);
    ext_irq_pin <= 1'b1;
    repeat (5) @(posedge clk_sys);
    wr(`MMD_A_EXTIRQ, 8'h07);
    rd_chk("ext irq level", `MMD_A_EXTIRQ, 32'h0000_000B);
    chk("ext irq masked", 32'h0000_0000, ext_irq_req);
    ext_irq_pin <= 1'b0;
    repeat (5) @(posedge clk_sys);
    wr(`MMD_A_EXTIRQ, 8'h04);
    rd_chk("ext irq level ack", `MMD_A_EXTIRQ, 32'h0000_0000);
  endtask
  task automatic t_regions();
    logic [31:0] t;
    for (int i = 0; i < 22; i++) begin
      mmd_host_inst.xfer(1'b0, RG_A[i], 8'h00, t);
      chk("region", RG_E[i], region);
    end
  endtask
  task automatic t_sysregs();
    rd_chk("reset cause", `MMD_A_RSTCAUSE, 32'h0000_0081);
    rd_chk("irq src one", `MMD_A_IRQS1, 32'h0000_0042);
    rd_chk("irq src two", `MMD_A_IRQS2, 32'h0000_0024);
    rd_chk("irq src three", `MMD_A_IRQS3, 32'h0000_0001);
    rd_chk("flash protect", `MMD_A_FLPROT, 32'h0000_00C3);
    rd_chk("option byte", `MMD_A_OPTION, 32'h0000_003C);
    wr(16'hFE07, 8'hFF);
    rd_chk("reserved fe07", 16'hFE07, 32'h0000_0000);
    wr(16'hFE0F, 8'hFF);
    rd_chk("reserved fe0f", 16'hFE0F, 32'h0000_0000);
    rd_chk("reserved io", 16'h0046, 32'h0000_0000);
  endtask
  task automatic t_break_flash();
    wr(`MMD_A_BREAKPOINT_ADDR_HIGH, 8'h12);
    wr(`MMD_A_BREAKPOINT_ADDR_LOW, 8'h34);
    rd_chk("brk low", `MMD_A_BREAKPOINT_ADDR_LOW, 32'h0000_0034);
    chk("brk addr", 32'h0000_1234, brk_addr);
    wr(`MMD_A_BRKSC, 8'h80);
    rd_chk("brk ctl", `MMD_A_BRKSC, 32'h0000_0080);
    chk("brk ctl out", 32'h0000_0080, brk_ctl);
    wr(`MMD_A_BRKSTAT, 8'h00);
    rd_chk("brk status", `MMD_A_BRKSTAT, 32'h0000_0000);
    wr(`MMD_A_BRKFLAG, 8'h80);
    rd_chk("brk flag", `MMD_A_BRKFLAG, 32'h0000_0080);
    wr(`MMD_A_FLCTL, 8'hFF);
    rd_chk("flash ctl", `MMD_A_FLCTL, 32'h0000_000F);
    chk("flash ctl out", 32'h0000_000F, flash_ctl);
    wr(`MMD_A_WDOG, 8'h55);
    #1;
    chk("wdog kick", 32'h0000_0001, wdog_kick);
    @(posedge clk_sys);
    #1;
    chk("wdog kick end", 32'h0000_0000, wdog_kick);
  endtask

  // ==========================================================
  // Main sequence: power-on reset for 8 cycles, then every scenario
  initial begin
    nrst        = 1'b0;
    npor        = 1'b0;
    ext_irq_pin = 1'b0;
    status_in   = '{8'h81, 8'h42, 8'h24, 8'h01, 8'hC3, 8'h3C, 1'b0};
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    npor <= 1'b1;
    t_keypad();
    t_cfg_once();
    t_ext_irq();
    t_regions();
    t_sysregs();
    t_break_flash();
    print_verdict();
  end
endmodule
